// ===== core/sic_defines.svh
// Purpose: offsets, field positions and reset values of the slot-id,
//          clock-gating and window 1 translation registers
// Assumes: byte offsets on an 8-bit configuration address
// Notes:   definitions only
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH

// register offsets
`define SIC_OFF_SLOT_ID 8'ha0
`define SIC_OFF_CLK_CTRL 8'ha4
`define SIC_OFF_XLAT_BASE 8'ha8
`define SIC_OFF_WIN1_SETUP 8'hac

// slot-identification dword
`define SIC_CAP_ID_VAL 8'h04
`define SIC_NEXT_PTR_VAL 8'hb0
`define SIC_SLOT_NUM_RST 5'h00
`define SIC_CHASSIS_RST 8'h00

// clock control fields
`define SIC_CODE_STOP 2'h3
`define SIC_CLK_CTRL_RST 16'h0000
`define SIC_BIT_DEV1 8
`define SIC_BIT_DEV2 9
`define SIC_BIT_FBK 10
`define SIC_BIT_STOPPED 13
`define SIC_BIT_CLKRUN_EN 14
`define SIC_BIT_MODE 15
`define SIC_CLK_WMASK 16'hc7ff
`define SIC_RUN_ALL 7'h7f

// window 1 translation and setup
`define SIC_XLAT_LSB 6
`define SIC_XLAT_RST 26'h0000000
`define SIC_SETUP_RST 32'h00000000
`define SIC_SETUP_EN 31
`define SIC_SETUP_WMASK 32'hfffffffe
`define SIC_SETUP_RSVD_KEEP 32'hffffffcf

`endif

// ===== core/sic_pkg.sv
// Purpose: shared types of the slot-id / clock-gating register group
// Assumes: nothing beyond the defines header
// Notes:   holds the clock-stop state type only
package sic_pkg;

  // secondary clock stop sequencing
  typedef enum logic [1:0] {
    SIC_RUN,
    SIC_STOP_WAIT,
    SIC_STOPPED
  } sic_stop_state_t;

endpackage

// ===== core/sic_regs.sv
// Purpose: slot-id capability, secondary clock gating with clkrun stop,
//          and window 1 address translation registers
// Assumes: ref_clk 50 MHz; secondary clocks are ref_clk divided by two
//          d3hot, idle and pending inputs are synchronous to ref_clk
// Notes:   clock gates change only in the low half of the divided clock
//          the stop status is raised with the last output pulse, at the edge that clears every run gate
//          the secondary clocks run at half of ref_clk; no other ratio is offered
//          address decode of the window itself lies outside this block
//
// Overview of operation
// [RULE1] slot_cap_identifier byte reads fixed 04h
// [RULE2] next pointer byte reads fixed b0h
// [RULE3] slot number, first flag writable; 23:22 zero
// [RULE4] chassis number writable, resets to zero
// [RULE5] slot clocks stop only on code 11
// [RULE6] bits 8, 9 stop device clocks
// [RULE7] bit 10 stops feedback clock, forward only
// [RULE8] bit 13 shows secondary clock stopped
// [RULE9] bit 14 enables clkrun stopping
// [RULE10] one mode stops only in d3hot
// [RULE11] other mode stops when bus idle
// [RULE12] translated base bits 31:6, low zero
// [RULE13] setup size selects used base bits
// [RULE14] setup marks size bits, bit 31 enables
// [RULE15] mode 0 is d3hot, 1 idle
// [RULE16] masked bits replaced, low bits passed
`timescale 1ns/100ps
`include "sic_defines.svh"

module sic_regs
  import sic_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic forward_mode,
  input wire logic d3hot_state,
  input wire logic sec_bus_idle,
  input wire logic pri_req_pending,
  input wire logic [31:0] xlat_addr_in,
  input wire logic xlat_valid_in,
  output logic [31:0] xlat_addr_out,
  output logic xlat_valid_out,
  output logic slot0_clock_out,
  output logic slot1_clock_out,
  output logic slot2_clock_out,
  output logic slot3_clock_out,
  output logic device1_clock_out,
  output logic device2_clock_out,
  output logic bridge_feedback_clock_out
);

  // address match, shared by every register decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // a slot clock runs for every code except the stop code
  function automatic logic slot_runs(input logic [1:0] code);
    slot_runs = (code != `SIC_CODE_STOP);
  endfunction

  // reset release through two flip-flops; assertion acts at once,
  // release only on an edge, so no register sees it in mid-setup
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rstn = rst_sync_ff;

  // bridge mode strap is a pin: two stages before use
  // a live strap change reaches the feedback gate two edges later
  logic fwd_meta_ff;
  logic fwd_sync_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_meta_ff <= 1'b0;
      fwd_sync_ff <= 1'b0;
    end else begin
      fwd_meta_ff <= forward_mode;
      fwd_sync_ff <= fwd_meta_ff;
    end
  end

  // register storage
  logic [4:0] slot_num_ff;
  logic first_in_chassis_ff;
  logic [7:0] chassis_ff;
  logic [15:0] clk_ctrl_ff;
  logic [31:`SIC_XLAT_LSB] xlat_base_ff;
  logic [31:0] win1_setup_ff;
  sic_stop_state_t stop_state_ff;

  // address decode, shared by the write strobes and the read mux
  wire sel_slot = hit(reg_addr, `SIC_OFF_SLOT_ID);
  wire sel_clk = hit(reg_addr, `SIC_OFF_CLK_CTRL);
  wire sel_base = hit(reg_addr, `SIC_OFF_XLAT_BASE);
  wire sel_setup = hit(reg_addr, `SIC_OFF_WIN1_SETUP);

  // write decode; an unmapped offset matches nothing and is dropped
  wire wr_slot = reg_wr && sel_slot;
  wire wr_clk = reg_wr && sel_clk;
  wire wr_base = reg_wr && sel_base;
  wire wr_setup = reg_wr && sel_setup;

  // slot id fields; slot_cap_identifier and next pointer are constants
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slot_num_ff <= `SIC_SLOT_NUM_RST; // [RULE3]
      first_in_chassis_ff <= 1'b0; // [RULE3]
      chassis_ff <= `SIC_CHASSIS_RST; // [RULE4]
    end else if (wr_slot) begin
      slot_num_ff <= reg_wdata[20:16]; // [RULE3]
      first_in_chassis_ff <= reg_wdata[21]; // [RULE3]
      chassis_ff <= reg_wdata[31:24]; // [RULE4]
    end
  end

  // writable clock control bits: 10:0, 14, 15; 13 is status, 12:11 reserved
  wire [15:0] clk_wmask = `SIC_CLK_WMASK;
  wire [15:0] nxt_clk_ctrl = (clk_ctrl_ff & ~clk_wmask) | (reg_wdata[15:0] & clk_wmask);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_ctrl_ff <= `SIC_CLK_CTRL_RST; // [RULE5] [RULE6] [RULE7] [RULE9]
    end else if (wr_clk) begin
      clk_ctrl_ff <= nxt_clk_ctrl; // [RULE9] [RULE10]
    end
  end

  // translated base: only bits 31:6 are stored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      xlat_base_ff <= `SIC_XLAT_RST;
    end else if (wr_base) begin
      xlat_base_ff <= reg_wdata[31:`SIC_XLAT_LSB]; // [RULE12]
    end
  end

  // window 1 setup: size bits 30:6 and enable 31 writable; bit 0 reads zero
  // reserved 5:4 read zero because the write data there is masked off
  wire [31:0] setup_wmask = `SIC_SETUP_WMASK & `SIC_SETUP_RSVD_KEEP;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      win1_setup_ff <= `SIC_SETUP_RST; // [RULE14]
    end else if (wr_setup) begin
      win1_setup_ff <= reg_wdata & setup_wmask; // [RULE14]
    end
  end

  // clkrun stop request: mode 0 waits for d3hot, mode 1 for an idle bus
  // the power-state, idle and pending inputs are already on ref_clk
  wire clkrun_en = clk_ctrl_ff[`SIC_BIT_CLKRUN_EN]; // [RULE9]
  wire stop_mode = clk_ctrl_ff[`SIC_BIT_MODE];
  wire idle_stop = sec_bus_idle && !pri_req_pending; // [RULE11]
  wire stop_cond = stop_mode ? idle_stop : d3hot_state; // [RULE10] [RULE11] [RULE15]
  wire stop_req = clkrun_en && stop_cond; // [RULE9]

  // divided secondary clock; gates change only while it is low,
  // which keeps every gated output free of runt pulses
  logic div_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= ~div_ff;
    end
  end

  // gate decisions are taken only at edges where the divided clock
  // is about to rise, so a change never shortens a high phase
  wire gate_slot = !div_ff;

  // stop sequencing: a request waits for the low phase before stopping
  // a request that drops while waiting cancels the stop, so a short
  // idle gap never cuts a pulse
  sic_stop_state_t nxt_stop_state;

  always_comb begin
    nxt_stop_state = stop_state_ff;
    case (stop_state_ff)
      SIC_RUN: begin
        if (stop_req) begin
          nxt_stop_state = SIC_STOP_WAIT;
        end
      end
      SIC_STOP_WAIT: begin
        if (!stop_req) begin
          nxt_stop_state = SIC_RUN;
        end else if (gate_slot) begin
          nxt_stop_state = SIC_STOPPED;
        end
      end
      SIC_STOPPED: begin
        if (!stop_req && gate_slot) begin
          nxt_stop_state = SIC_RUN;
        end
      end
      default: begin
        nxt_stop_state = SIC_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stop_state_ff <= SIC_RUN;
    end else begin
      stop_state_ff <= nxt_stop_state;
    end
  end

  wire sec_stopped = (stop_state_ff == SIC_STOPPED); // [RULE8]

  // run gates are cleared at the very edge that enters the stopped state;
  // that edge still starts a last output pulse, during which the status bit already reports a stop
  wire stop_next = (nxt_stop_state == SIC_STOPPED); // [RULE8]

  // single stop bits; the feedback gate is honoured only in forward mode,
  // in reverse mode its bit is stored but has no effect
  wire dev1_stop = clk_ctrl_ff[`SIC_BIT_DEV1];
  wire dev2_stop = clk_ctrl_ff[`SIC_BIT_DEV2];
  wire fbk_stop = fwd_sync_ff && clk_ctrl_ff[`SIC_BIT_FBK];

  // per-output run enables, sampled at the low phase only
  wire [6:0] run_req;

  assign run_req[0] = slot_runs(clk_ctrl_ff[1:0]); // [RULE5]
  assign run_req[1] = slot_runs(clk_ctrl_ff[3:2]); // [RULE5]
  assign run_req[2] = slot_runs(clk_ctrl_ff[5:4]); // [RULE5]
  assign run_req[3] = slot_runs(clk_ctrl_ff[7:6]); // [RULE5]
  assign run_req[4] = !dev1_stop; // [RULE6]
  assign run_req[5] = !dev2_stop; // [RULE6]
  assign run_req[6] = !fbk_stop; // [RULE7]

  logic [6:0] run_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_ff <= `SIC_RUN_ALL;
    end else if (gate_slot) begin
      run_ff <= run_req & {7{!stop_next}}; // [RULE8]
    end
  end

  // clock outputs: a stopped clock is held low
  // every pin is a flip-flop output, so no gating glitch can reach it
  wire [6:0] nxt_clk_out = {7{!div_ff}} & run_ff;
  logic [6:0] clk_out_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_out_ff <= 7'h00;
    end else begin
      clk_out_ff <= nxt_clk_out; // [RULE5] [RULE6] [RULE7]
    end
  end

  assign slot0_clock_out = clk_out_ff[0];
  assign slot1_clock_out = clk_out_ff[1];
  assign slot2_clock_out = clk_out_ff[2];
  assign slot3_clock_out = clk_out_ff[3];
  assign device1_clock_out = clk_out_ff[4];
  assign device2_clock_out = clk_out_ff[5];
  assign bridge_feedback_clock_out = clk_out_ff[6];

  // translation: size bits pick which base bits replace the address
  wire win1_en = win1_setup_ff[`SIC_SETUP_EN]; // [RULE14]
  wire [31:0] size_mask = {1'b1, win1_setup_ff[30:`SIC_XLAT_LSB], 6'h00}; // [RULE13]
  wire [31:0] base_full = {xlat_base_ff, 6'h00};
  // bits picked by the size mask come from the translated base,
  // the rest of the initiator address passes through untouched
  wire [31:0] xlat_from_base = base_full & size_mask; // [RULE16]
  wire [31:0] xlat_from_addr = xlat_addr_in & ~size_mask; // [RULE16]
  wire [31:0] nxt_xlat_addr = xlat_from_base | xlat_from_addr;

  // valid is marked only while the window is enabled
  wire nxt_xlat_valid = xlat_valid_in && win1_en; // [RULE14]

  // a disabled window passes transactions untranslated and unmarked
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      xlat_addr_out <= 32'h00000000;
      xlat_valid_out <= 1'b0;
    end else begin
      xlat_addr_out <= win1_en ? nxt_xlat_addr : xlat_addr_in; // [RULE13] [RULE16]
      xlat_valid_out <= nxt_xlat_valid;
    end
  end

  // read data words; slot-id dword bytes low to high
  wire [7:0] slot_cap_identifier = `SIC_CAP_ID_VAL; // [RULE1]
  wire [7:0] slot_cap_next_link = `SIC_NEXT_PTR_VAL; // [RULE2]
  wire [7:0] expansion_slot_info = {2'h0, first_in_chassis_ff, slot_num_ff}; // [RULE3]
  wire [7:0] chassis_index = chassis_ff; // [RULE4]
  wire [31:0] rd_slot = {chassis_index, expansion_slot_info, slot_cap_next_link, slot_cap_identifier};
  // clock control view: bit 13 is live status, 12:11 read zero
  wire [15:0] clk_view = {clk_ctrl_ff[15:14], sec_stopped, 2'h0, clk_ctrl_ff[10:0]}; // [RULE8]
  wire [31:0] rd_clk = {16'h0000, clk_view};
  wire [31:0] rd_base = {xlat_base_ff, 6'h00}; // [RULE12]
  wire [31:0] rd_setup = win1_setup_ff;

  // read mux; unmapped offsets read zero
  wire [31:0] nxt_rdata =
    sel_slot ? rd_slot :
    sel_clk ? rd_clk :
    sel_base ? rd_base :
    sel_setup ? rd_setup : 32'h00000000;

  // read data stands only in the cycle after the strobe
  // and is zero otherwise, so several blocks may share an or-ed bus
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// ===== sim/sic_regs_chk.sv
// Purpose: port-level checker for the slot-id and clock-gating registers
// Assumes: read data stands only in the cycle after the read strobe
// Notes: attached by the bind after the module
`timescale 1ns/100ps
module sic_regs_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic xlat_valid_in,
  input wire logic xlat_valid_out,
  input wire logic slot0_clock_out,
  input wire logic device1_clock_out,
  input wire logic bridge_feedback_clock_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // read-back of fixed fields, judged in the cycle after the strobe
  chk_cap_id_fixed: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha0 |-> reg_rdata[7:0] == 8'h04)
    else $error("slot_cap_identifier byte wrong");
  chk_next_ptr_fixed: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha0 |->
    reg_rdata[15:8] == 8'hb0)
    else $error("next pointer byte wrong");
  chk_slot_resv_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha0 |->
    reg_rdata[23:22] == 2'h0)
    else $error("slot dword reserved bits set");
  chk_base_low_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha8 |->
    reg_rdata[5:0] == 6'h00)
    else $error("translated base low bits set");
  // a stopped status must agree with the pins actually being low
  chk_stop_status_pins: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha4 && reg_rdata[13] |->
    !slot0_clock_out && !device1_clock_out && !bridge_feedback_clock_out)
    else $error("status says stopped while a clock runs");
  // no valid output without a qualified input one cycle before
  chk_xlat_valid_src: assert property (xlat_valid_out |-> $past(xlat_valid_in))
    else $error("translation valid without input");
  // divided clocks are never high two cycles running
  chk_slot_clk_half: assert property (slot0_clock_out |=> !slot0_clock_out)
    else $error("slot clock high too long");
  chk_dev_clk_half: assert property (device1_clock_out |=> !device1_clock_out)
    else $error("device clock high too long");
  chk_fbk_clk_half: assert property ($rose(bridge_feedback_clock_out) |=> $fell(bridge_feedback_clock_out))
    else $error("feedback clock high too long");
endmodule

bind sic_regs sic_regs_chk u_sic_regs_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xlat_valid_in(xlat_valid_in), .xlat_valid_out(xlat_valid_out),
  .slot0_clock_out(slot0_clock_out), .device1_clock_out(device1_clock_out),
  .bridge_feedback_clock_out(bridge_feedback_clock_out));

// ===== sim/tb.sv
// Purpose: self-checking bench for sic_regs
// Assumes: bus strobes with a one-cycle gap between accesses
// Notes: read and translation results are queued and checked by a monitor
`timescale 1ns/100ps
module tb;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_pend = 0;
  logic fwd = 1, d3 = 0, idle = 0, pend = 0, xv = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, xin = 32'h0, r, m;
  logic [6:0] seen;
  logic [15:0] ctab [10] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'hc, 16'h30, 16'hc0, 16'h100, 16'h200, 16'h400};
  logic [6:0] etab [10] = '{7'h7f, 7'h7f, 7'h7f, 7'h7e, 7'h7d, 7'h7b, 7'h77, 7'h6f, 7'h5f, 7'h3f};
  wire [31:0] reg_rdata, xout;
  wire [6:0] ck;
  wire xvo;
  logic [31:0] rq[$], xq[$];
  int bad_count = 0, samples_checked = 0;

  always #10 ref_clk = ~ref_clk;

  sic_regs u_sic_regs (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .forward_mode(fwd), .d3hot_state(d3),
    .sec_bus_idle(idle), .pri_req_pending(pend), .xlat_addr_in(xin), .xlat_valid_in(xv),
    .xlat_addr_out(xout), .xlat_valid_out(xvo), .slot0_clock_out(ck[0]), .slot1_clock_out(ck[1]),
    .slot2_clock_out(ck[2]), .slot3_clock_out(ck[3]), .device1_clock_out(ck[4]),
    .device2_clock_out(ck[5]), .bridge_feedback_clock_out(ck[6]));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h want %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a gap cycle after each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  // collect which clocks toggled over eight cycles once the gates settle
  task automatic clk_chk(input logic [15:0] c, input logic [6:0] exp);
    wr(8'ha4, {16'h0, c});
    repeat (6) @(posedge ref_clk);
    seen = 7'h0;
    repeat (8) begin
      @(negedge ref_clk);
      seen = seen | ck;
    end
    @(posedge ref_clk);
    check({25'h0, seen}, {25'h0, exp});
  endtask

  // monitor: read data is looked at only in its one valid cycle
  always @(posedge ref_clk) rd_pend <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_pend) check(reg_rdata, rq.pop_front());
    if (xvo && xq.size() > 0) check(xout, xq.pop_front());
    else if (xvo) check(32'h1, 32'h0);
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    r = $urandom(65);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(8'ha0, 32'h0000b004);
    rd(8'ha4, 32'h0);
    rd(8'ha8, 32'h0);
    rd(8'hac, 32'h0);
    rd(8'h9c, 32'h0);
    repeat (4) begin
      r = $urandom;
      wr(8'ha0, r);
      rd(8'ha0, {r[31:24], 2'h0, r[21:16], 16'hb004});
      wr(8'ha8, r);
      rd(8'ha8, r & 32'hffffffc0);
      wr(8'ha4, r & 32'hffffbfff);
      rd(8'ha4, r & 32'h000087ff);
    end
    for (int i = 0; i < 10; i++) clk_chk(ctab[i], etab[i]);
    fwd <= 1'b0;
    clk_chk(16'h0400, 7'h7f);
    d3 <= 1'b1;
    clk_chk(16'h0000, 7'h7f);
    clk_chk(16'h4000, 7'h00);
    rd(8'ha4, 32'h00006000);
    d3 <= 1'b0;
    clk_chk(16'h4000, 7'h7f);
    rd(8'ha4, 32'h00004000);
    idle <= 1'b1;
    pend <= 1'b1;
    clk_chk(16'hc000, 7'h7f);
    pend <= 1'b0;
    clk_chk(16'hc000, 7'h00);
    rd(8'ha4, 32'h0000e000);
    wr(8'ha4, 32'h0);
    idle <= 1'b0;
    wr(8'hac, 32'hfff0000e);
    rd(8'hac, 32'hfff0000e);
    m = 32'hfff00000;
    wr(8'ha8, r);
    repeat (6) begin
      xin <= $urandom;
      xv <= 1'b1;
      @(negedge ref_clk);
      xq.push_back((r & m) | (xin & ~m));
      @(posedge ref_clk);
    end
    xv <= 1'b0;
    wr(8'hac, 32'h0);
    xv <= 1'b1;
    repeat (3) @(posedge ref_clk);
    xv <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // reset again in mid-run: fields written earlier must clear
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(8'ha0, 32'h0000b004);
    rd(8'ha8, 32'h0);
    print_verdict();
  end
endmodule
